// ---- common/ssf_pkg.sv ----
package ssf_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] START_SAMPLE_SETUP_ADDR = 8'h00_DB;
   localparam logic [7:0] START_SAMPLE_SETUP_RST = 8'h00_00;
   localparam int SAMPLE_ENABLE_BIT = 7;
   localparam int SAMPLE_FIELD_MSB = 6;
   localparam int SAMPLE_FIELD_LSB = 0;
   localparam int SAMPLE_FIELD_W = 7;
   // ==========================================================
   // timing
   localparam int OSC_PERIOD_NS = 8;
   localparam int MAX_SCL_KHZ = 833;
   localparam int MIN_SCL_PERIOD_NS =
      (1000000 + MAX_SCL_KHZ - 1) / MAX_SCL_KHZ;
   localparam int MIN_SCL_CYCLES = MIN_SCL_PERIOD_NS / OSC_PERIOD_NS;
   localparam int ADDR_BITS = 7;
   // ==========================================================
   // qualifier states
   typedef enum logic [3:0] {
      SSF_IDLE = 4'b0001,
      SSF_CHECK = 4'b0010,
      SSF_ADDR = 4'b0100,
      SSF_DONE = 4'b1000
   } ssf_state_e;
endpackage

// ---- verilog/ssf_sync.sv ----
`timescale 1ns/100ps
module ssf_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // async level in, synchronised level out
   input wire logic d_i,
   output logic q_o
);
   logic meta_reg;
   logic meta_next;
   logic q_reg;
   logic q_next;

   // next values: two stage chain
   always_comb begin
      meta_next = d_i;
      q_next = meta_reg;
   end

   // bus lines idle high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= 1'b1;
         q_reg <= 1'b1;
      end else begin
         meta_reg <= meta_next;
         q_reg <= q_next;
      end
   end

   assign q_o = q_reg;
endmodule

// ---- verilog/ssf_filter.sv ----
`timescale 1ns/100ps
module ssf_filter (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // special function register port
   input wire logic [7:0] SFR_ADDR_I,
   input wire logic [7:0] SFR_WDATA_I,
   input wire logic SFR_WR_I,
   input wire logic SFR_RD_I,
   output logic [7:0] SFR_RDATA_O,
   // engine context
   input wire logic SLAVE_MODE_I,
   input wire logic [6:0] OWN_SLAVE_ADDRESS_I,
   input wire logic FLAG_CLEAR_I,
   // bus lines
   input wire logic SDA_I,
   input wire logic SCL_I,
   // status out
   output logic START_VALID_O,
   output logic START_REJECT_O,
   output logic XFER_DONE_O,
   output logic ADDR_MATCH_O
);
   logic sda_s;
   logic scl_s;
   logic sda_d_reg;
   logic sda_d_next;
   logic [7:0] setup_reg;
   logic [7:0] setup_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   ssf_pkg::ssf_state_e state_reg;
   ssf_pkg::ssf_state_e state_next;
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic [7:0] need;
   logic [3:0] bit_reg;
   logic [3:0] bit_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic scl_d_reg;
   logic scl_d_next;
   logic valid_reg;
   logic valid_next;
   logic reject_reg;
   logic reject_next;
   logic done_reg;
   logic done_next;
   logic match_reg;
   logic match_next;
   logic fall_edge;
   logic samp_ok;
   logic scl_rise;
   logic en_val;
   logic [6:0] field_val;

   // ==========================================================
   // pin synchronisers
   ssf_sync u_sda (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .d_i(SDA_I),
      .q_o(sda_s)
   );
   ssf_sync u_scl (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .d_i(SCL_I),
      .q_o(scl_s)
   );

   // ==========================================================
   // setup register
   // map and reset
   always_comb begin
      setup_next = setup_reg;
      rdata_next = rdata_reg;
      if (SFR_WR_I && SFR_ADDR_I == ssf_pkg::START_SAMPLE_SETUP_ADDR) begin
         setup_next = SFR_WDATA_I;
      end
      if (SFR_RD_I) begin
         rdata_next = (SFR_ADDR_I == ssf_pkg::START_SAMPLE_SETUP_ADDR)
            ? setup_reg : 8'h00_00;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         setup_reg <= ssf_pkg::START_SAMPLE_SETUP_RST;
         rdata_reg <= 8'h00_00;
      end else begin
         setup_reg <= setup_next;
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // start qualifier
   // falling data with clock high
   assign fall_edge = SLAVE_MODE_I && sda_d_reg && !sda_s && scl_s;
   assign samp_ok = !sda_s && scl_s;
   // rise seen only in the oscillator cycle where scl_s is high and was low
   assign scl_rise = scl_s && !scl_d_reg;
   // setup fields
   assign en_val = setup_reg[ssf_pkg::SAMPLE_ENABLE_BIT];
   assign field_val =
      setup_reg[ssf_pkg::SAMPLE_FIELD_MSB:ssf_pkg::SAMPLE_FIELD_LSB];
   assign need = en_val ? {1'b0, field_val} + 8'h00_01 : 8'h00_01;

   // next state of qualifier and address shifter
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      bit_next = bit_reg;
      shift_next = shift_reg;
      sda_d_next = sda_s;
      scl_d_next = scl_s;
      valid_next = 1'b0;
      reject_next = 1'b0;
      done_next = done_reg;
      match_next = match_reg;
      // set wins over clear
      if (FLAG_CLEAR_I) begin
         done_next = 1'b0;
         match_next = 1'b0;
      end
      unique case (state_reg)
         ssf_pkg::SSF_IDLE: begin
            cnt_next = 8'h00_00;
            if (fall_edge) begin
               state_next = ssf_pkg::SSF_CHECK;
            end
         end
         ssf_pkg::SSF_CHECK: begin
            if (!samp_ok) begin
               reject_next = 1'b1;
               state_next = ssf_pkg::SSF_IDLE;
            end else if (cnt_reg + 8'h00_01 == need) begin
               valid_next = 1'b1;
               bit_next = 4'h0_0;
               shift_next = 8'h00_00;
               state_next = ssf_pkg::SSF_ADDR;
            end else begin
               cnt_next = cnt_reg + 8'h00_01;
            end
         end
         ssf_pkg::SSF_ADDR: begin
            if (scl_rise) begin
               shift_next = {shift_reg[6:0], sda_s};
               bit_next = bit_reg + 4'h0_1;
               if (bit_reg == 4'h0_6) begin
                  state_next = ssf_pkg::SSF_DONE;
               end
            end
         end
         ssf_pkg::SSF_DONE: begin
            if (shift_reg[6:0] == OWN_SLAVE_ADDRESS_I) begin
               done_next = 1'b1;
               match_next = 1'b1;
            end
            state_next = ssf_pkg::SSF_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         state_reg <= ssf_pkg::SSF_IDLE;
         cnt_reg <= 8'h00_00;
         bit_reg <= 4'h0_0;
         shift_reg <= 8'h00_00;
         sda_d_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         valid_reg <= 1'b0;
         reject_reg <= 1'b0;
         done_reg <= 1'b0;
         match_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         sda_d_reg <= sda_d_next;
         scl_d_reg <= scl_d_next;
         valid_reg <= valid_next;
         reject_reg <= reject_next;
         done_reg <= done_next;
         match_reg <= match_next;
      end
   end

   // outputs straight from flops
   assign SFR_RDATA_O = rdata_reg;
   assign START_VALID_O = valid_reg;
   assign START_REJECT_O = reject_reg;
   assign XFER_DONE_O = done_reg;
   assign ADDR_MATCH_O = match_reg;

   // ==========================================================
   // assertions
   a_edge_starts: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      (state_reg == ssf_pkg::SSF_IDLE && fall_edge)
      |=> state_reg == ssf_pkg::SSF_CHECK)
      else $error("start edge not taken");
   a_single_sample: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      (state_reg == ssf_pkg::SSF_CHECK && !en_val && samp_ok)
      |=> valid_reg)
      else $error("single sample did not validate");
   a_count_exact: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      valid_reg |-> $past(cnt_reg)
         == ($past(en_val) ? {1'b0, $past(field_val)} : 8'h00_00))
      else $error("sample count wrong");
   a_sample_step: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      (state_reg == ssf_pkg::SSF_CHECK && samp_ok && !valid_next)
      |=> cnt_reg == $past(cnt_reg) + 8'h00_01)
      else $error("samples not one clock apart");
   a_valid_cause: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      valid_reg |-> $past(samp_ok) && state_reg == ssf_pkg::SSF_ADDR)
      else $error("valid without good sample");
   a_reject_idle: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      (state_reg == ssf_pkg::SSF_CHECK && !samp_ok)
      |=> reject_reg && state_reg == ssf_pkg::SSF_IDLE)
      else $error("bad sample not rejected");
   a_match_flags: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      (state_reg == ssf_pkg::SSF_DONE
       && shift_reg[6:0] == OWN_SLAVE_ADDRESS_I)
      |=> done_reg && match_reg)
      else $error("match flags not set");
   a_reg_write: assert property (@(posedge CLK_I)
      disable iff (RST_I)
      (SFR_WR_I && SFR_ADDR_I == ssf_pkg::START_SAMPLE_SETUP_ADDR)
      |=> setup_reg == $past(SFR_WDATA_I))
      else $error("setup write lost");
endmodule

// ---- test/ssf_master_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// bus master model, both lines pulled high while idle
module ssf_master_model (
   input wire logic clk_i,
   output logic sda_o,
   output logic scl_o
);
   // phase length keeps scl at or below the rate limit
   localparam int PH = ssf_pkg::MIN_SCL_CYCLES / 3 + 1;
   initial begin
      sda_o = 1'h1;
      scl_o = 1'h1;
   end
   // drive both lines just after a falling edge, then hold n cycles
   task automatic set(input logic d, input logic c, input int n);
      @(negedge clk_i);
      sda_o = d;
      scl_o = c;
      repeat (n) @(negedge clk_i);
   endtask
   task automatic send(input logic [6:0] a);
      for (int i = 6; i >= 0; i--) begin
         set(sda_o, 1'h0, PH);
         set(a[i], 1'h0, PH);
         set(a[i], 1'h1, PH);
      end
      // stop: data rises while clock high
      set(1'h0, 1'h0, PH);
      set(1'h0, 1'h1, PH);
      set(1'h1, 1'h1, 2 * PH);
   endtask
endmodule

// ---- test/ssf_filter_test.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s); end end
// ==========================================================
// start qualifier bench
module ssf_filter_test;
   logic clk, rst, wr, rd, slv, clr, sda, scl, vld, rej, xd, am;
   logic [7:0] addr, wdata, rdata, rv, s;
   logic [6:0] own;
   logic [7:0] tbl [9];
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int nv = 0;
   int nr = 0;
   int tv = 0;
   int t0, lat, lat0, v0, r0;
   // design and far-side master
   ssf_filter ssf_filter_i (.CLK_I(clk), .RST_I(rst), .SFR_ADDR_I(addr),
      .SFR_WDATA_I(wdata), .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_RDATA_O(rdata),
      .SLAVE_MODE_I(slv), .OWN_SLAVE_ADDRESS_I(own), .FLAG_CLEAR_I(clr),
      .SDA_I(sda), .SCL_I(scl), .START_VALID_O(vld), .START_REJECT_O(rej),
      .XFER_DONE_O(xd), .ADDR_MATCH_O(am));
   ssf_master_model ssf_master_model_i (.clk_i(clk), .sda_o(sda),
      .scl_o(scl));
   // clock
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // count cycles and status pulses
   always @(posedge clk) begin
      cyc++;
      if (vld === 1'h1) begin
         nv++;
         tv = cyc;
      end
      if (rej === 1'h1) nr++;
   end
   // expected number of confirming samples
   function automatic int exp_n(input logic [7:0] v);
      return v[7] ? int'(v[6:0]) + 1 : 1;
   endfunction
   // register write and read
   task automatic reg_wr(input logic [7:0] a8, input logic [7:0] d);
      @(negedge clk);
      addr = a8;
      wdata = d;
      wr = 1'h1;
      @(negedge clk);
      wr = 1'h0;
   endtask
   task automatic reg_rd(input logic [7:0] a8, output logic [7:0] d);
      @(negedge clk);
      addr = a8;
      rd = 1'h1;
      @(negedge clk);
      rd = 1'h0;
      @(negedge clk);
      d = rdata;
   endtask
   // held start then address; latency of the valid pulse kept in lat
   task automatic run(input logic [7:0] v, input logic [6:0] ad);
      reg_wr(8'h00_DB, v);
      v0 = nv;
      t0 = cyc;
      ssf_master_model_i.set(1'h0, 1'h1, exp_n(v) + 8);
      `CHK("valid", v0 + 1, nv)
      lat = tv - t0;
      ssf_master_model_i.send(ad);
      `CHK("match", ad == own, am)
      `CHK("done", ad == own, xd)
      clr = 1'h1;
      @(negedge clk);
      clr = 1'h0;
      @(negedge clk);
      `CHK("cleared", 1'h0, am)
      `CHK("cleared done", 1'h0, xd)
   endtask
   // verdict
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      finish_test();
   end
   // main sequence
   initial begin
      rst = 1'h1;
      wr = 1'h0;
      rd = 1'h0;
      slv = 1'h1;
      clr = 1'h0;
      addr = 8'h00_00;
      wdata = 8'h00_00;
      void'($urandom(32'h6aa8));
      own = 7'($urandom);
      tbl = '{8'h00_7F, 8'h00_80, 8'h00_81, 8'h00_8B, 8'h00_97, 8'h00_FF,
         8'h00_80 | 8'($urandom), 8'h00_93, 8'h00_84};
      repeat (5) @(negedge clk);
      rst = 1'h0;
      reg_rd(8'h00_DB, rv);
      `CHK("setup reset", 8'h00_00, rv)
      reg_wr(8'h00_DA, 8'h00_FF);
      reg_rd(8'h00_DB, rv);
      `CHK("other write", 8'h00_00, rv)
      reg_rd(8'h00_DA, rv);
      `CHK("unmapped", 8'h00_00, rv)
      s = 8'($urandom);
      reg_wr(8'h00_DB, s);
      reg_rd(8'h00_DB, rv);
      `CHK("setup rw", s, rv)
      $display("test registers done");
      run(8'h00_00, own);
      lat0 = lat;
      foreach (tbl[i]) begin
         run(tbl[i], (i % 2 == 1) ? own : ~own);
         `CHK("samples", exp_n(tbl[i]) - 1, lat - lat0)
      end
      $display("test sample counts done");
      reg_wr(8'h00_DB, 8'h00_97);
      r0 = nr;
      v0 = nv;
      ssf_master_model_i.set(1'h0, 1'h1, 3);
      ssf_master_model_i.set(1'h1, 1'h1, 40);
      `CHK("reject sda", r0 + 1, nr)
      ssf_master_model_i.set(1'h0, 1'h1, 3);
      ssf_master_model_i.set(1'h0, 1'h0, 5);
      ssf_master_model_i.set(1'h1, 1'h0, 5);
      ssf_master_model_i.set(1'h1, 1'h1, 40);
      `CHK("reject scl", r0 + 2, nr)
      `CHK("no valid", v0, nv)
      run(8'h00_97, own);
      $display("test rejects done");
      slv = 1'h0;
      v0 = nv;
      ssf_master_model_i.set(1'h0, 1'h1, 40);
      ssf_master_model_i.set(1'h1, 1'h1, 20);
      `CHK("master valid", v0, nv)
      `CHK("master reject", r0 + 2, nr)
      $display("test slave mode done");
      finish_test();
   end
endmodule
